// file: rtl/crs_pkg.sv
/*
  crs_pkg: shared constants and types for the core register set.
  assumes: single 100 MHz clock, synchronous active-high reset.
*/
package crs_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 16;
  // condition flag bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_I0 = 3;
  localparam int FLAG_H = 4;
  localparam int FLAG_I1 = 5;
  // reset pattern 111x1xxx with the undefined bits taken as zero
  localparam logic [7:0] FLAGS_RESET = 8'h_00E8;
  localparam logic [7:0] FLAGS_FIXED_ONES = 8'h_00C0;
  // priority field codes {high, low}
  localparam logic [1:0] PRIO_LVL0 = 2'h_2;
  localparam logic [1:0] PRIO_LVL1 = 2'h_1;
  localparam logic [1:0] PRIO_LVL2 = 2'h_0;
  localparam logic [1:0] PRIO_LVL3 = 2'h_3;
  localparam logic [7:0] SP_RESET_LOW = 8'h_00FF;
  localparam logic [7:0] SP_HIGH_FIXED = 8'h_0001;
  localparam logic [15:0] RESET_VECTOR_ADDR = 16'h_FFFE;
  localparam int CALL_FRAME = 2;
  localparam int IRQ_FRAME = 5;
  localparam int NUM_BASIC_INSTR = 63;
  localparam int NUM_ADDR_MODES = 17;

  typedef enum logic [4:0] {
    OP_NONE = 5'h_00, OP_ADD = 5'h_01, OP_ADC = 5'h_02, OP_SUB = 5'h_03,
    OP_SBC = 5'h_04, OP_AND = 5'h_05, OP_OR = 5'h_06, OP_XOR = 5'h_07,
    OP_LD = 5'h_08, OP_CP = 5'h_09, OP_SHL = 5'h_0A, OP_SHR = 5'h_0B,
    OP_RLC = 5'h_0C, OP_RRC = 5'h_0D, OP_MUL = 5'h_0E, OP_SCF = 5'h_0F,
    OP_RCF = 5'h_10, OP_RIM = 5'h_11, OP_SIM = 5'h_12, OP_BTJ = 5'h_13,
    OP_INC = 5'h_14, OP_DEC = 5'h_15
  } crs_op_t;

  typedef enum logic [1:0] {DST_A = 2'h_0, DST_X = 2'h_1, DST_Y = 2'h_2} crs_dst_t;

  typedef enum logic [3:0] {
    BR_HALF = 4'h_0, BR_NO_HALF = 4'h_1, BR_MINUS = 4'h_2, BR_PLUS = 4'h_3,
    BR_EQUAL = 4'h_4, BR_NOT_EQUAL = 4'h_5, BR_CARRY = 4'h_6, BR_NO_CARRY = 4'h_7,
    BR_ALWAYS = 4'h_8
  } crs_branch_t;

  typedef struct packed {
    logic valid;
    crs_op_t op;
    crs_dst_t dst;
    logic use_second_index;
    logic [7:0] operand;
    logic [2:0] bit_sel;
  } crs_alu_req_t;

  typedef struct packed {
    logic [7:0] a;
    logic [7:0] x;
    logic [7:0] y;
    logic [15:0] pc;
    logic [7:0] sp_low;
    logic [7:0] flags;
  } crs_regs_t;
endpackage

// file: rtl/crs_stack_ram.sv
/*
  crs_stack_ram: 256-byte stack memory with registered read data.
  assumes: one write or one read per cycle, same clock as the core.
*/
module crs_stack_ram #(
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  input wire logic mclk,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem [DEPTH];
  logic [7:0] rdata_d;

  always_comb begin
    rdata_d = mem[addr];
  end

  always_ff @(posedge mclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= rdata_d;
  end
endmodule

// file: rtl/crs_core_regs.sv
/*
  crs_core_regs: programmer-visible register set of an 8-bit core with
  accumulator, two index registers, program counter, stack pointer and
  condition flags, plus the flag-producing arithmetic unit.
  assumes: an instruction sequencer outside drives one request per
  cycle, supplies the interrupt priority bits of the serviced source,
  and presents the reset vector bytes while vector_load is high.
*/
module crs_core_regs (
  input wire logic mclk,
  input wire logic reset,
  input wire crs_pkg::crs_alu_req_t alu_req,
  input wire logic pc_load,
  input wire logic [15:0] pc_load_value,
  input wire logic pc_incr,
  input wire logic vector_load,
  input wire logic [15:0] vector_value,
  input wire logic call_start,
  input wire logic ret_start,
  input wire logic irq_enter,
  input wire logic [1:0] irq_priority,
  input wire logic irq_return,
  input wire logic halt_instr,
  input wire logic wait_for_interrupt_instr,
  input wire logic push_flags,
  input wire logic pop_flags,
  input wire logic flags_write,
  input wire logic [7:0] flags_write_value,
  input wire logic sp_reset_instr,
  input wire logic sp_load,
  input wire logic [7:0] sp_load_value,
  input wire crs_pkg::crs_branch_t branch_sel,
  output logic branch_taken,
  output crs_pkg::crs_regs_t regs,
  output logic [15:0] stack_addr,
  output logic busy,
  output logic [7:0] mul_high
);
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_PUSH = 5'b00010,
    ST_POP_WAIT = 5'b00100,
    ST_POP = 5'b01000,
    ST_POP_DONE = 5'b10000
  } crs_state_t;

  // frame order on the stack, first byte at the current pointer
  typedef enum logic [2:0] {
    FR_PCL = 3'h_0, FR_PCH = 3'h_1, FR_X = 3'h_2, FR_A = 3'h_3, FR_CC = 3'h_4
  } crs_frame_t;

  crs_state_t state_q, state_d;
  logic [7:0] a_q, a_d, x_q, x_d, y_q, y_d, pcl_q, pcl_d, pch_q, pch_d;
  logic [7:0] sp_q, sp_d, flags_q, flags_d, mul_high_q, mul_high_d;
  logic [2:0] idx_q, idx_d, len_q, len_d;
  logic irq_frame_q, irq_frame_d;
  logic ram_we;
  logic [7:0] ram_addr, ram_wdata, ram_rdata;
  logic [7:0] src;
  logic [8:0] sum;
  logic [3:0] low_sum;
  logic [7:0] res;
  logic [15:0] prod;
  logic res_valid, carry_new, carry_upd, half_upd;

  function automatic logic [7:0] fix_flags(input logic [7:0] v);
    fix_flags = v | crs_pkg::FLAGS_FIXED_ONES;
  endfunction

  function automatic logic [7:0] set_prio(input logic [7:0] v, input logic [1:0] p);
    logic [7:0] r;
    r = v;
    r[crs_pkg::FLAG_I1] = p[1];
    r[crs_pkg::FLAG_I0] = p[0];
    set_prio = r;
  endfunction

  function automatic logic [7:0] frame_byte(input logic [2:0] i, input crs_pkg::crs_regs_t r);
    unique case (i)
      FR_PCL: frame_byte = r.pc[7:0];
      FR_PCH: frame_byte = r.pc[15:8];
      FR_X: frame_byte = r.x;
      FR_A: frame_byte = r.a;
      default: frame_byte = r.flags;
    endcase
  endfunction

  crs_stack_ram #(
    .DEPTH(256),
    .AW(8)
  ) u_stack (
    .mclk(mclk),
    .we(ram_we),
    .addr(ram_addr),
    .wdata(ram_wdata),
    .rdata(ram_rdata)
  );

  // arithmetic unit
  always_comb begin
    src = alu_req.use_second_index ? y_q : x_q;
    if (alu_req.dst == crs_pkg::DST_A) begin
      src = a_q;
    end
    sum = 9'h_000;
    low_sum = 4'h_0;
    res = 8'h_00;
    prod = 16'h_0000;
    res_valid = 1'b1;
    carry_new = flags_q[crs_pkg::FLAG_C];
    carry_upd = 1'b0;
    half_upd = 1'b0;
    unique case (alu_req.op)
      crs_pkg::OP_ADD, crs_pkg::OP_ADC: begin
        sum = {1'b0, src} + {1'b0, alu_req.operand}
          + {8'h_00, alu_req.op == crs_pkg::OP_ADC && flags_q[crs_pkg::FLAG_C]};
        low_sum = src[3:0] + alu_req.operand[3:0];
        low_sum = 4'(({1'b0, src[3:0]} + {1'b0, alu_req.operand[3:0]}
          + {4'h_0, alu_req.op == crs_pkg::OP_ADC && flags_q[crs_pkg::FLAG_C]}) >> 4);
        res = sum[7:0];
        carry_new = sum[8];
        carry_upd = 1'b1;
        half_upd = 1'b1;
      end
      crs_pkg::OP_SUB, crs_pkg::OP_SBC, crs_pkg::OP_CP: begin
        sum = {1'b0, src} - {1'b0, alu_req.operand}
          - {8'h_00, alu_req.op == crs_pkg::OP_SBC && flags_q[crs_pkg::FLAG_C]};
        res = sum[7:0];
        carry_new = sum[8];
        carry_upd = 1'b1;
      end
      crs_pkg::OP_AND: res = src & alu_req.operand;
      crs_pkg::OP_OR: res = src | alu_req.operand;
      crs_pkg::OP_XOR: res = src ^ alu_req.operand;
      crs_pkg::OP_LD: res = alu_req.operand;
      crs_pkg::OP_INC: res = src + 8'h_01;
      crs_pkg::OP_DEC: res = src - 8'h_01;
      crs_pkg::OP_SHL: begin
        res = {src[6:0], 1'b0};
        carry_new = src[7];
        carry_upd = 1'b1;
      end
      crs_pkg::OP_SHR: begin
        res = {1'b0, src[7:1]};
        carry_new = src[0];
        carry_upd = 1'b1;
      end
      crs_pkg::OP_RLC: begin
        res = {src[6:0], flags_q[crs_pkg::FLAG_C]};
        carry_new = src[7];
        carry_upd = 1'b1;
      end
      crs_pkg::OP_RRC: begin
        res = {flags_q[crs_pkg::FLAG_C], src[7:1]};
        carry_new = src[0];
        carry_upd = 1'b1;
      end
      crs_pkg::OP_MUL: begin
        prod = x_q * a_q;
        res = prod[7:0];
        carry_new = 1'b0;
        carry_upd = 1'b1;
        half_upd = 1'b1;
      end
      crs_pkg::OP_BTJ: begin
        res_valid = 1'b0;
        carry_new = alu_req.operand[alu_req.bit_sel];
        carry_upd = 1'b1;
      end
      default: res_valid = 1'b0;
    endcase
  end

  // branch condition evaluation on the current flags
  always_comb begin
    unique case (branch_sel)
      crs_pkg::BR_HALF: branch_taken = flags_q[crs_pkg::FLAG_H];
      crs_pkg::BR_NO_HALF: branch_taken = !flags_q[crs_pkg::FLAG_H];
      crs_pkg::BR_MINUS: branch_taken = flags_q[crs_pkg::FLAG_N];
      crs_pkg::BR_PLUS: branch_taken = !flags_q[crs_pkg::FLAG_N];
      crs_pkg::BR_EQUAL: branch_taken = flags_q[crs_pkg::FLAG_Z];
      crs_pkg::BR_NOT_EQUAL: branch_taken = !flags_q[crs_pkg::FLAG_Z];
      crs_pkg::BR_CARRY: branch_taken = flags_q[crs_pkg::FLAG_C];
      crs_pkg::BR_NO_CARRY: branch_taken = !flags_q[crs_pkg::FLAG_C];
      default: branch_taken = 1'b1;
    endcase
  end

  // register and stack sequencing
  always_comb begin
    state_d = state_q;
    a_d = a_q;
    x_d = x_q;
    y_d = y_q;
    pcl_d = pcl_q;
    pch_d = pch_q;
    sp_d = sp_q;
    flags_d = flags_q;
    mul_high_d = mul_high_q;
    idx_d = idx_q;
    len_d = len_q;
    irq_frame_d = irq_frame_q;
    ram_we = 1'b0;
    ram_addr = sp_q;
    ram_wdata = frame_byte(idx_q, regs);
    unique case (state_q)
      ST_IDLE: begin
        if (pc_incr) begin
          {pch_d, pcl_d} = {pch_q, pcl_q} + 16'h_0001;
        end
        if (pc_load) begin
          {pch_d, pcl_d} = pc_load_value;
        end
        if (alu_req.valid) begin
          if (res_valid && alu_req.op != crs_pkg::OP_CP) begin
            unique case (alu_req.dst)
              crs_pkg::DST_A: a_d = res;
              crs_pkg::DST_X: x_d = res;
              default: y_d = res;
            endcase
          end
          if (alu_req.op == crs_pkg::OP_MUL) begin
            x_d = prod[15:8];
            a_d = prod[7:0];
            mul_high_d = prod[15:8];
          end
          if (res_valid) begin
            flags_d[crs_pkg::FLAG_N] = res[7];
            flags_d[crs_pkg::FLAG_Z] = (res == 8'h_00);
          end
          if (half_upd) begin
            flags_d[crs_pkg::FLAG_H] = (alu_req.op == crs_pkg::OP_MUL) ? 1'b0 : low_sum[0];
          end
          if (carry_upd) begin
            flags_d[crs_pkg::FLAG_C] = carry_new;
          end
          unique case (alu_req.op)
            crs_pkg::OP_SCF: flags_d[crs_pkg::FLAG_C] = 1'b1;
            crs_pkg::OP_RCF: flags_d[crs_pkg::FLAG_C] = 1'b0;
            crs_pkg::OP_RIM: flags_d = set_prio(flags_q, crs_pkg::PRIO_LVL0);
            crs_pkg::OP_SIM: flags_d = set_prio(flags_q, crs_pkg::PRIO_LVL3);
            default: flags_d = flags_d;
          endcase
        end
        if (halt_instr || wait_for_interrupt_instr) begin
          // built on flags_d so a flag result of the same cycle is not lost
          flags_d = set_prio(flags_d, crs_pkg::PRIO_LVL0);
        end
        if (flags_write) begin
          flags_d = flags_write_value;
        end
        if (sp_load) begin
          sp_d = sp_load_value;
        end
        if (sp_reset_instr) begin
          sp_d = crs_pkg::SP_RESET_LOW;
        end
        if (vector_load) begin
          {pch_d, pcl_d} = vector_value;
        end
        if (push_flags) begin
          ram_we = 1'b1;
          ram_wdata = flags_q;
          sp_d = sp_q - 8'h_01;
        end else if (pop_flags) begin
          sp_d = sp_q + 8'h_01;
          idx_d = 3'(FR_CC);
          len_d = 3'h_1;
          irq_frame_d = 1'b0;
          state_d = ST_POP_WAIT;
        end else if (irq_enter || call_start) begin
          // pcl lands where the pointer stands, the rest follow downwards
          idx_d = 3'(FR_PCL);
          len_d = irq_enter ? 3'(crs_pkg::IRQ_FRAME) : 3'(crs_pkg::CALL_FRAME);
          irq_frame_d = irq_enter;
          state_d = ST_PUSH;
        end else if (irq_return || ret_start) begin
          sp_d = sp_q + 8'h_01;
          // the last byte pushed sits just above the pointer, so popping runs backwards
          idx_d = irq_return ? 3'(crs_pkg::IRQ_FRAME - 1) : 3'(crs_pkg::CALL_FRAME - 1);
          len_d = irq_return ? 3'(crs_pkg::IRQ_FRAME) : 3'(crs_pkg::CALL_FRAME);
          irq_frame_d = irq_return;
          state_d = ST_POP_WAIT;
        end
      end
      ST_PUSH: begin
        ram_we = 1'b1;
        ram_wdata = frame_byte(irq_frame_q ? idx_q : {2'b00, idx_q[0]}, regs);
        sp_d = sp_q - 8'h_01;
        if (idx_q + 3'h_1 == len_q) begin
          if (irq_frame_q) begin
            flags_d = set_prio(flags_q, irq_priority);
          end
          state_d = ST_IDLE;
        end else begin
          idx_d = idx_q + 3'h_1;
        end
      end
      ST_POP_WAIT: begin
        state_d = ST_POP;
      end
      ST_POP: begin
        unique case (idx_q)
          FR_PCL: pcl_d = ram_rdata;
          FR_PCH: pch_d = ram_rdata;
          FR_X: x_d = ram_rdata;
          FR_A: a_d = ram_rdata;
          default: flags_d = ram_rdata;
        endcase
        if (idx_q == 3'h_0 || len_q == 3'h_1) begin
          state_d = ST_POP_DONE;
        end else begin
          idx_d = idx_q - 3'h_1;
          sp_d = sp_q + 8'h_01;
          state_d = ST_POP_WAIT;
        end
      end
      ST_POP_DONE: begin
        state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
    flags_d = fix_flags(flags_d);
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_q <= ST_IDLE;
      a_q <= 8'h_00;
      x_q <= 8'h_00;
      y_q <= 8'h_00;
      pcl_q <= 8'h_00;
      pch_q <= 8'h_00;
      sp_q <= crs_pkg::SP_RESET_LOW;
      flags_q <= crs_pkg::FLAGS_RESET;
      mul_high_q <= 8'h_00;
      idx_q <= 3'h_0;
      len_q <= 3'h_0;
      irq_frame_q <= 1'b0;
    end else begin
      state_q <= state_d;
      a_q <= a_d;
      x_q <= x_d;
      y_q <= y_d;
      pcl_q <= pcl_d;
      pch_q <= pch_d;
      sp_q <= sp_d;
      flags_q <= flags_d;
      mul_high_q <= mul_high_d;
      idx_q <= idx_d;
      len_q <= len_d;
      irq_frame_q <= irq_frame_d;
    end
  end

  // registers leave only through this port, never through a data address
  always_comb begin
    regs.a = a_q;
    regs.x = x_q;
    regs.y = y_q;
    regs.pc = {pch_q, pcl_q};
    regs.sp_low = sp_q;
    regs.flags = flags_q;
  end

  assign stack_addr = {crs_pkg::SP_HIGH_FIXED, sp_q};
  assign busy = (state_q != ST_IDLE);
  assign mul_high = mul_high_q;
endmodule

// file: dv/crs_core_regs_checker.sv
/*
  crs_core_regs_checker: concurrent checks on the ports of the core register set.
  assumes: bound to crs_core_regs, one clock mclk, synchronous active-high reset.
*/
module crs_core_regs_checker (
  input wire logic mclk,
  input wire logic reset,
  input wire crs_pkg::crs_alu_req_t alu_req,
  input wire logic call_start,
  input wire logic ret_start,
  input wire logic irq_enter,
  input wire logic irq_return,
  input wire logic [1:0] irq_priority,
  input wire logic push_flags,
  input wire logic pop_flags,
  input wire logic flags_write,
  input wire crs_pkg::crs_branch_t branch_sel,
  input wire logic branch_taken,
  input wire crs_pkg::crs_regs_t regs,
  input wire logic [15:0] stack_addr,
  input wire logic busy,
  input wire logic [7:0] mul_high
);
  timeunit 1ns;
  timeprecision 100ps;
  logic free;
  logic alu_go;
  logic irq_go;
  logic add_a;
  logic [4:0] h_sum;
  logic [15:0] prod;
  // the alu checks only count a request made in idle with no frame, flag write or stack strobe in the same cycle
  assign free = !busy && !flags_write && !push_flags && !pop_flags;
  assign irq_go = free && irq_enter;
  assign alu_go = free && alu_req.valid && !irq_enter && !call_start && !irq_return
    && !ret_start;
  assign add_a = alu_go && alu_req.op == crs_pkg::OP_ADD && alu_req.dst == crs_pkg::DST_A;
  assign h_sum = {1'b0, regs.a[3:0]} + {1'b0, alu_req.operand[3:0]};
  // the multiply takes its operands from the two registers, not from the request
  assign prod = {8'h00, regs.x} * {8'h00, regs.a};

  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  chk_fixed_ones: assert property (regs.flags[7:6] == 2'b11)
    else $error("flag bits 7 and 6 not one");
  chk_reset_state: assert property ($fell(reset) |-> regs.flags == crs_pkg::FLAGS_RESET)
    else $error("flags wrong after reset");
  chk_stack_page: assert property (stack_addr[15:8] == 8'h01)
    else $error("stack page not fixed");
  chk_add_half: assert property (add_a |=> regs.flags[crs_pkg::FLAG_H] == $past(h_sum[4]))
    else $error("half carry wrong after add");
  chk_zero_result: assert property (add_a |=> regs.flags[crs_pkg::FLAG_Z] == (regs.a == 8'h00))
    else $error("zero flag wrong after add");
  chk_neg_copy: assert property (alu_go && alu_req.op == crs_pkg::OP_LD && alu_req.dst == crs_pkg::DST_A
    |=> regs.a == $past(alu_req.operand) && regs.flags[crs_pkg::FLAG_N] == regs.a[7])
    else $error("negative flag not result bit 7");
  chk_carry_force: assert property (alu_go && alu_req.op inside {crs_pkg::OP_SCF, crs_pkg::OP_RCF}
    |=> regs.flags[crs_pkg::FLAG_C] == $past(alu_req.op == crs_pkg::OP_SCF))
    else $error("carry not forced");
  chk_carry_branch: assert property (branch_sel == crs_pkg::BR_CARRY |-> branch_taken == regs.flags[0])
    else $error("carry branch wrong");
  chk_frame_busy: assert property (irq_go |=> busy [*5] ##1 !busy)
    else $error("interrupt frame length wrong");
  chk_frame_sp: assert property (irq_go |=> ##5 regs.sp_low == $past(regs.sp_low, 6) - 8'd5)
    else $error("interrupt frame stack depth wrong");
  chk_irq_prio: assert property (irq_go |=> ##5 {regs.flags[5], regs.flags[3]} == $past(irq_priority))
    else $error("priority not loaded on entry");
  chk_y_kept: assert property (busy |=> regs.y == $past(regs.y))
    else $error("second index changed by frame");
  chk_mul_high: assert property (alu_go && alu_req.op == crs_pkg::OP_MUL |=> mul_high == $past(prod[15:8]))
    else $error("multiply high byte wrong");

  cov_irq: cover property (irq_go);
  cov_mul: cover property (alu_go && alu_req.op == crs_pkg::OP_MUL);
  cov_half: cover property (add_a && h_sum[4]);
endmodule

// file: dv/crs_core_regs_tb.sv
/*
  crs_core_regs_tb: directed sequences of strobes and alu requests with expected values.
  assumes: crs_pkg, crs_core_regs and crs_core_regs_checker are compiled before it.
*/
module crs_core_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk, reset, pc_load, pc_incr, vector_load, call_start, ret_start, irq_enter;
  logic irq_return, halt_instr, wait_for_interrupt_instr, push_flags, pop_flags;
  logic flags_write, sp_reset_instr, sp_load, branch_taken, busy;
  logic [1:0] irq_priority;
  logic [1:0] prio;
  logic [7:0] flags_write_value, sp_load_value, mul_high;
  logic [15:0] pc_load_value, vector_value, stack_addr;
  logic [8:0] br_exp;
  crs_pkg::crs_alu_req_t alu_req;
  crs_pkg::crs_branch_t branch_sel;
  crs_pkg::crs_regs_t regs;
  int n_fail, n_checks, cycles;

  assign prio = {regs.flags[crs_pkg::FLAG_I1], regs.flags[crs_pkg::FLAG_I0]};

  crs_core_regs i_dut (.mclk, .reset, .alu_req, .pc_load, .pc_load_value, .pc_incr,
    .vector_load, .vector_value, .call_start, .ret_start, .irq_enter, .irq_priority,
    .irq_return, .halt_instr, .wait_for_interrupt_instr, .push_flags, .pop_flags,
    .flags_write, .flags_write_value, .sp_reset_instr, .sp_load, .sp_load_value,
    .branch_sel, .branch_taken, .regs, .stack_addr, .busy, .mul_high);

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // the whole sequence needs about 115 cycles, so this only trips on a hang
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      close_out();
    end
  end

  task automatic step();
    @(posedge mclk);
    #1;
  endtask

  task automatic chk(logic [15:0] seen, logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      n_fail++;
    end
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 20 && busy !== 1'b0; i++) step();
    chk(busy, 1'b0);
  endtask

  // strobes are held one full cycle, then a quiet cycle keeps requests apart
  task automatic pulse(ref logic s);
    s = 1'b1;
    step();
    s = 1'b0;
    step();
    wait_idle();
  endtask

  task automatic alu(crs_pkg::crs_op_t op, crs_pkg::crs_dst_t d, logic [7:0] v);
    alu_req = '{valid: 1'b1, op: op, dst: d, use_second_index: (d == crs_pkg::DST_Y),
      operand: v, bit_sel: 3'h0};
    step();
    alu_req.valid = 1'b0;
    step();
  endtask

  task automatic done(string s);
    $display("test %s finished", s);
  endtask

  initial begin
    {pc_load, pc_incr, vector_load, call_start, ret_start, irq_enter, irq_return} = '0;
    {halt_instr, wait_for_interrupt_instr, push_flags, pop_flags, flags_write} = '0;
    {sp_reset_instr, sp_load, irq_priority, flags_write_value, sp_load_value} = '0;
    {pc_load_value, vector_value} = '0;
    alu_req = '0;
    branch_sel = crs_pkg::BR_ALWAYS;
    reset = 1'b1;
    repeat (20) step();
    reset = 1'b0;
    step();
    chk(regs.flags, crs_pkg::FLAGS_RESET);
    chk(regs.a, 8'h00);
    chk(stack_addr, 16'h01FF);
    done("reset");
    alu(crs_pkg::OP_LD, crs_pkg::DST_A, 8'h0F);
    alu(crs_pkg::OP_ADD, crs_pkg::DST_A, 8'h01);
    chk(regs.a, 8'h10);
    chk(regs.flags, 8'hF8);
    alu(crs_pkg::OP_ADD, crs_pkg::DST_A, 8'hF0);
    chk(regs.flags, 8'hEB);
    alu(crs_pkg::OP_LD, crs_pkg::DST_A, 8'h80);
    chk(regs.flags, 8'hED);
    br_exp = 9'h166;
    for (int i = 0; i < 9; i++) begin
      branch_sel = crs_pkg::crs_branch_t'(4'(i));
      step();
      chk(branch_taken, br_exp[i]);
    end
    alu(crs_pkg::OP_RCF, crs_pkg::DST_A, 8'h00);
    chk(regs.flags[0], 1'b0);
    alu(crs_pkg::OP_SCF, crs_pkg::DST_A, 8'h00);
    chk(regs.flags[0], 1'b1);
    done("flags");
    alu(crs_pkg::OP_LD, crs_pkg::DST_X, 8'h5A);
    alu(crs_pkg::OP_LD, crs_pkg::DST_Y, 8'hA5);
    chk(regs.x, 8'h5A);
    chk(regs.y, 8'hA5);
    alu(crs_pkg::OP_SIM, crs_pkg::DST_A, 8'h00);
    chk(prio, crs_pkg::PRIO_LVL3);
    pulse(halt_instr);
    chk(prio, crs_pkg::PRIO_LVL0);
    alu(crs_pkg::OP_SIM, crs_pkg::DST_A, 8'h00);
    pulse(wait_for_interrupt_instr);
    chk(prio, crs_pkg::PRIO_LVL0);
    flags_write_value = 8'h00;
    pulse(flags_write);
    chk(regs.flags, 8'hC0);
    chk(prio, crs_pkg::PRIO_LVL2);
    alu(crs_pkg::OP_RIM, crs_pkg::DST_A, 8'h00);
    chk(prio, crs_pkg::PRIO_LVL0);
    alu(crs_pkg::OP_LD, crs_pkg::DST_X, 8'h10);
    alu(crs_pkg::OP_LD, crs_pkg::DST_A, 8'h12);
    alu(crs_pkg::OP_MUL, crs_pkg::DST_A, 8'h00);
    chk(regs.a, 8'h20);
    chk(regs.x, 8'h01);
    chk(mul_high, 8'h01);
    done("priority and multiply");
    flags_write_value = 8'hE8;
    pulse(flags_write);
    irq_priority = crs_pkg::PRIO_LVL1;
    irq_enter = 1'b1;
    step();
    irq_enter = 1'b0;
    call_start = 1'b1;
    step();
    call_start = 1'b0;
    wait_idle();
    chk(stack_addr, 16'h01FA);
    chk(prio, crs_pkg::PRIO_LVL1);
    chk(regs.y, 8'hA5);
    alu(crs_pkg::OP_LD, crs_pkg::DST_A, 8'h33);
    pulse(irq_return);
    chk(regs.a, 8'h20);
    chk(regs.flags, 8'hE8);
    chk(stack_addr, 16'h01FF);
    done("interrupt frame");
    sp_load_value = 8'h00;
    pulse(sp_load);
    pulse(call_start);
    chk(stack_addr, 16'h01FE);
    pulse(ret_start);
    chk(stack_addr, 16'h0100);
    pulse(sp_reset_instr);
    chk(stack_addr, 16'h01FF);
    flags_write_value = 8'hC1;
    pulse(flags_write);
    pulse(push_flags);
    chk(stack_addr, 16'h01FE);
    flags_write_value = 8'h00;
    pulse(flags_write);
    pulse(pop_flags);
    chk(regs.flags, 8'hC1);
    done("stack");
    vector_value = 16'h1234;
    pulse(vector_load);
    chk(regs.pc, 16'h1234);
    pulse(pc_incr);
    chk(regs.pc, 16'h1235);
    pc_load_value = 16'hABCD;
    pulse(pc_load);
    chk(regs.pc, 16'hABCD);
    done("program counter");
    close_out();
  end
endmodule

bind crs_core_regs crs_core_regs_checker i_chk (.mclk, .reset, .alu_req, .call_start,
  .ret_start, .irq_enter, .irq_return, .irq_priority, .push_flags, .pop_flags,
  .flags_write, .branch_sel, .branch_taken, .regs, .stack_addr, .busy, .mul_high);
